// [core/dei_chan_regs.vh]
// Purpose: Register map, field positions and reset values of the channel event block.
// Assumes: 32-bit classic Wishbone slave, byte addresses, word aligned.
// Notes: Definitions only.
`ifndef DEI_CHAN_REGS_VH
`define DEI_CHAN_REGS_VH

// Register byte offsets (all four address bits decode)
`define DEI_ADDR_W 4
`define DEI_OFS_EVENT_CTRL 4'h0
`define DEI_OFS_INT_CTRL 4'h4
`define DEI_OFS_FLAG_CLR 4'h8
`define DEI_OFS_STATE 4'hC

// Event control fields
`define DEI_EC_ABORT_SEL_HI 23
`define DEI_EC_ABORT_SEL_LO 16
`define DEI_EC_START_SEL_HI 15
`define DEI_EC_START_SEL_LO 8
`define DEI_EC_FORCE_BIT 7
`define DEI_EC_SABORT_BIT 6
`define DEI_EC_PAT_EN_BIT 5
`define DEI_EC_START_EN_BIT 4
`define DEI_EC_ABORT_EN_BIT 3

// Byte lanes of the write enables
`define DEI_LANE_LOW 0
`define DEI_LANE_MID 1
`define DEI_LANE_HIGH 2

// Interrupt control fields
`define DEI_IC_IE_HI 23
`define DEI_IC_IE_LO 16
`define DEI_IC_IF_HI 7
`define DEI_IC_IF_LO 0

// Flag bit positions inside the eight-bit flag field
`define DEI_F_SRC_DONE 7
`define DEI_F_SRC_HALF 6
`define DEI_F_DST_DONE 5
`define DEI_F_DST_HALF 4
`define DEI_F_BLOCK 3
`define DEI_F_CELL 2
`define DEI_F_ABORT 1
`define DEI_F_ADDR_ERR 0

// State register fields
`define DEI_ST_CHAN_ON_BIT 0
`define DEI_ST_IRQ_BIT 1

// Reset values
`define DEI_SEL_RESET 8'hFF
`define DEI_BYTE_RESET 8'h00
`define DEI_BIT_RESET 1'b0
`define DEI_WORD_ZERO 32'h0000_0000

// Size field: zero encodes the largest region, whose half is this value
`define DEI_SIZE_W 16
`define DEI_HALF_OF_ZERO 16'h8000
`define DEI_SIZE_ZERO 16'h0000
`define DEI_IRQ_COUNT 256

`endif

// [core/dei_channel_ctrl.v]
// Purpose: Per-channel start/abort event selection and interrupt flags of a DMA channel.
// Assumes: Classic Wishbone slave, one clock, datapath supplies pointers and strobes.
// Notes: Start and abort outputs are one-cycle registered pulses.
//   Writes land on the ack edge; reads capture data on the request edge.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dei_chan_regs.vh"

// Operation
// - Abort selector names interrupt 0..255 that aborts transfer and sets abort flag.
// - Start selector names interrupt 0..255 that starts a transfer when enabled.
// - Abort enable set lets selected interrupt abort; clear ignores it.
// - Start enable set lets selected interrupt start a cell; clear ignores it.
// - Writing one to force bit starts a transfer; it reads zero.
// - Writing one to soft abort bit aborts the transfer; it reads zero.
// - Pattern abort enable makes pattern match abort and clear channel enable.
// - Eight read-write interrupt enables in bits 23..16, reset zero.
// - Source done flag sets when source pointer equals source size.
// - Source half flag sets when source pointer equals half source size.
// - Destination done flag sets when destination pointer equals destination size.
// - Unimplemented bits of both registers read as zero.
// - Destination half flag sets when pointer equals half destination size.
// - Block flag on block done or enabled pattern abort; cell flag on cell done.
// - Abort flag sets when selected abort interrupt aborts the transfer.
// - Address error flag sets on invalid source or destination address.
module dei_channel_ctrl (
  input wire clock,
  input wire reset_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`DEI_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // System interrupt request lines
  input wire [`DEI_IRQ_COUNT-1:0] irq_lines,
  // Datapath side
  input wire channel_on,
  input wire [`DEI_SIZE_W-1:0] source_pointer,
  input wire [`DEI_SIZE_W-1:0] source_size,
  input wire [`DEI_SIZE_W-1:0] destination_pointer,
  input wire [`DEI_SIZE_W-1:0] destination_size,
  input wire cell_done,
  input wire block_done,
  input wire pattern_match,
  input wire addr_error,
  output reg xfer_start_q,
  output reg xfer_abort_q,
  output reg channel_off_q,
  output wire irq_out
);

  // Event control storage
  reg [7:0] abort_irq_select_q;
  reg [7:0] start_irq_select_q;
  reg pattern_abort_enable_q;
  reg start_trigger_enable_q;
  reg abort_trigger_enable_q;

  // Interrupt control storage
  reg [7:0] int_enable_q;
  reg [7:0] int_flag_q;
  reg [7:0] int_flag_d;

  // Pointer compare history
  reg src_done_hit_q;
  reg src_half_hit_q;
  reg dst_done_hit_q;
  reg dst_half_hit_q;

  wire start_hit;
  wire abort_hit;
  wire bus_req;
  wire wr_go;
  wire rd_go;
  wire sel_ec;
  wire sel_ic;
  wire sel_fc;
  wire sel_st;
  wire [`DEI_SIZE_W-1:0] src_half;
  wire [`DEI_SIZE_W-1:0] dst_half;
  wire src_done_eq;
  wire src_half_eq;
  wire dst_done_eq;
  wire dst_half_eq;
  wire force_wr;
  wire sabort_wr;
  wire irq_abort;
  wire pat_abort;
  wire [7:0] set_vec;
  wire [7:0] clr_vec;
  wire [31:0] ec_read;
  wire [31:0] ic_read;
  wire [31:0] st_read;
  reg [31:0] rd_mux;

  // Decoded lane writes and gated start
  wire irq_start;
  wire ec_wr_lane0;
  wire ec_wr_lane1;
  wire ec_wr_lane2;
  wire ic_wr_lane0;
  wire ic_wr_lane2;
  wire fc_wr_lane0;

  // Start interrupt edge detector
  dei_irq_match u_start_match (
    .clock(clock),
    .reset_n(reset_n),
    .irq_lines(irq_lines),
    .select(start_irq_select_q),
    .hit_q(start_hit)
  );

  // Abort interrupt edge detector
  dei_irq_match u_abort_match (
    .clock(clock),
    .reset_n(reset_n),
    .irq_lines(irq_lines),
    .select(abort_irq_select_q),
    .hit_q(abort_hit)
  );

  // Bus decode: request answered one cycle later, write lands on ack edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_go = bus_req & wb_we_i & wb_ack_o;
  assign rd_go = bus_req & ~wb_we_i & ~wb_ack_o;
  assign sel_ec = (wb_adr_i == `DEI_OFS_EVENT_CTRL);
  assign sel_ic = (wb_adr_i == `DEI_OFS_INT_CTRL);
  assign sel_fc = (wb_adr_i == `DEI_OFS_FLAG_CLR);
  assign sel_st = (wb_adr_i == `DEI_OFS_STATE);

  // Per-register lane writes, all timed by the ack edge
  assign ec_wr_lane0 = wr_go & sel_ec & wb_sel_i[`DEI_LANE_LOW];
  assign ec_wr_lane1 = wr_go & sel_ec & wb_sel_i[`DEI_LANE_MID];
  assign ec_wr_lane2 = wr_go & sel_ec & wb_sel_i[`DEI_LANE_HIGH];
  assign ic_wr_lane0 = wr_go & sel_ic & wb_sel_i[`DEI_LANE_LOW];
  assign ic_wr_lane2 = wr_go & sel_ic & wb_sel_i[`DEI_LANE_HIGH];
  assign fc_wr_lane0 = wr_go & sel_fc & wb_sel_i[`DEI_LANE_LOW];

  // Acknowledge for one cycle per request, unmapped included
  // A request still held after ack is answered again after one low cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // abort selector
  // Abort selector, upper lane
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      abort_irq_select_q <= `DEI_SEL_RESET;
    end else if (ec_wr_lane2) begin
      abort_irq_select_q <= wb_dat_i[`DEI_EC_ABORT_SEL_HI:`DEI_EC_ABORT_SEL_LO];
    end
  end

  // start selector
  // Start selector, middle lane
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_irq_select_q <= `DEI_SEL_RESET;
    end else if (ec_wr_lane1) begin
      start_irq_select_q <= wb_dat_i[`DEI_EC_START_SEL_HI:`DEI_EC_START_SEL_LO];
    end
  end

  // start enable bit
  // Enable bits, low lane; force and soft abort are not stored
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pattern_abort_enable_q <= `DEI_BIT_RESET;
      start_trigger_enable_q <= `DEI_BIT_RESET;
      abort_trigger_enable_q <= `DEI_BIT_RESET;
    end else if (ec_wr_lane0) begin
      pattern_abort_enable_q <= wb_dat_i[`DEI_EC_PAT_EN_BIT];
      start_trigger_enable_q <= wb_dat_i[`DEI_EC_START_EN_BIT];
      abort_trigger_enable_q <= wb_dat_i[`DEI_EC_ABORT_EN_BIT];
    end
  end

  // soft abort write strobe
  // Set-only bits act once and are never stored
  assign force_wr = ec_wr_lane0 & wb_dat_i[`DEI_EC_FORCE_BIT];
  assign sabort_wr = ec_wr_lane0 & wb_dat_i[`DEI_EC_SABORT_BIT];

  assign irq_abort = abort_hit & abort_trigger_enable_q;
  assign pat_abort = pattern_match & pattern_abort_enable_q;

  // start gating
  // Selected start interrupt passes only while enabled
  assign irq_start = start_hit & start_trigger_enable_q;

  // forced start
  // Start pulse
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      xfer_start_q <= `DEI_BIT_RESET;
    end else begin
      xfer_start_q <= irq_start | force_wr;
    end
  end

  // soft abort
  // Abort pulse from interrupt, soft or pattern cause
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      xfer_abort_q <= `DEI_BIT_RESET;
    end else begin
      xfer_abort_q <= irq_abort | sabort_wr | pat_abort;
    end
  end

  // channel enable clear
  // Channel-off pulse only on a pattern abort
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      channel_off_q <= `DEI_BIT_RESET;
    end else begin
      channel_off_q <= pat_abort;
    end
  end

  // Half points; size zero stands for the largest region
  assign src_half = (source_size == `DEI_SIZE_ZERO) ? `DEI_HALF_OF_ZERO : (source_size >> 1);
  assign dst_half = (destination_size == `DEI_SIZE_ZERO) ? `DEI_HALF_OF_ZERO :
                    (destination_size >> 1);

  assign src_done_eq = channel_on & (source_pointer == source_size);
  assign src_half_eq = channel_on & (source_pointer == src_half);
  assign dst_done_eq = channel_on & (destination_pointer == destination_size);
  assign dst_half_eq = channel_on & (destination_pointer == dst_half);

  // Compare history so a flag sets once per arrival
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      src_done_hit_q <= 1'b0;
      src_half_hit_q <= 1'b0;
      dst_done_hit_q <= 1'b0;
      dst_half_hit_q <= 1'b0;
    end else begin
      src_done_hit_q <= src_done_eq;
      src_half_hit_q <= src_half_eq;
      dst_done_hit_q <= dst_done_eq;
      dst_half_hit_q <= dst_half_eq;
    end
  end

  // address error flag
  // Flag set vector
  assign set_vec[`DEI_F_SRC_DONE] = src_done_eq & ~src_done_hit_q;
  assign set_vec[`DEI_F_SRC_HALF] = src_half_eq & ~src_half_hit_q;
  assign set_vec[`DEI_F_DST_DONE] = dst_done_eq & ~dst_done_hit_q;
  assign set_vec[`DEI_F_DST_HALF] = dst_half_eq & ~dst_half_hit_q;
  assign set_vec[`DEI_F_BLOCK] = block_done | pat_abort;
  assign set_vec[`DEI_F_CELL] = cell_done;
  assign set_vec[`DEI_F_ABORT] = irq_abort;
  assign set_vec[`DEI_F_ADDR_ERR] = addr_error;

  // zero write clears
  // Clear vector: zero written to the flag field, or one to the clear alias
  assign clr_vec = ({8{ic_wr_lane0}} & ~wb_dat_i[`DEI_IC_IF_HI:`DEI_IC_IF_LO]) |
                   ({8{fc_wr_lane0}} & wb_dat_i[`DEI_IC_IF_HI:`DEI_IC_IF_LO]);

  // Next flags, a set in the clear cycle wins
  always @* begin
    int_flag_d = (int_flag_q & ~clr_vec) | set_vec;
  end

  // enable field
  // Enable field, upper lane
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      int_enable_q <= `DEI_BYTE_RESET;
    end else if (ic_wr_lane2) begin
      int_enable_q <= wb_dat_i[`DEI_IC_IE_HI:`DEI_IC_IE_LO];
    end
  end

  // flags reset clear
  // Flag field, updated every cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      int_flag_q <= `DEI_BYTE_RESET;
    end else begin
      int_flag_q <= int_flag_d;
    end
  end

  assign irq_out = |(int_flag_q & int_enable_q);

  // zero unimplemented bits
  // Read images
  assign ec_read = {8'h00, abort_irq_select_q, start_irq_select_q, 2'b00,
                    pattern_abort_enable_q, start_trigger_enable_q,
                    abort_trigger_enable_q, 3'b000};
  assign ic_read = {8'h00, int_enable_q, 8'h00, int_flag_q};
  assign st_read = {30'h0000_0000, irq_out, channel_on};

  // Read select, unmapped reads zero
  always @* begin
    rd_mux = `DEI_WORD_ZERO;
    if (sel_ec) begin
      rd_mux = ec_read;
    end else if (sel_ic) begin
      rd_mux = ic_read;
    end else if (sel_fc) begin
      rd_mux = {24'h00_0000, int_flag_q};
    end else if (sel_st) begin
      rd_mux = st_read;
    end
  end

  // Read data registered alongside ack
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= `DEI_WORD_ZERO;
    end else if (rd_go) begin
      wb_dat_o <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// [core/dei_irq_match.v]
// Purpose: Turns the rising edge of one selected system interrupt line into a pulse.
// Assumes: Interrupt lines are synchronous to clock.
// Notes: Each line keeps its own history so a change of selector makes no false edge.
`timescale 1ns/1ps
`default_nettype none
`include "dei_chan_regs.vh"

module dei_irq_match (
  input wire clock,
  input wire reset_n,
  input wire [`DEI_IRQ_COUNT-1:0] irq_lines,
  input wire [7:0] select,
  output reg hit_q
);

  reg [`DEI_IRQ_COUNT-1:0] prev_q;
  wire [`DEI_IRQ_COUNT-1:0] rise;

  // Per-line history and edge
  genvar i;
  generate
    for (i = 0; i < `DEI_IRQ_COUNT; i = i + 1) begin : g_line
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          prev_q[i] <= 1'b0;
        end else begin
          prev_q[i] <= irq_lines[i];
        end
      end
      assign rise[i] = irq_lines[i] & ~prev_q[i];
    end
  endgenerate

  // Registered pulse for the selected line
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= rise[select];
    end
  end

endmodule
`default_nettype wire

// [dv/dei_chan_props.sv]
// Purpose: Port checks for the channel event block.
// Assumes: Sees only top-level ports.
// Notes: Bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
module dei_chan_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pattern_match,
  input wire logic xfer_start_q,
  input wire logic xfer_abort_q,
  input wire logic channel_off_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Bus answer and reserved bits
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  property p_ec_zero; wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |->
    wb_dat_o[31:24] == 8'h00 && wb_dat_o[7:6] == 2'b00 && wb_dat_o[2:0] == 3'b000; endproperty
  a_ec_zero: assert property (p_ec_zero) else $error("event ctrl spare bits");
  property p_ic_zero; wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |->
    wb_dat_o[31:24] == 8'h00 && wb_dat_o[15:8] == 8'h00; endproperty
  a_ic_zero: assert property (p_ic_zero) else $error("int ctrl spare bits");
  property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'b00 |-> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // Pattern abort and strobe pulses
  property p_off_cause; channel_off_q |-> $past(pattern_match); endproperty
  a_off_cause: assert property (p_off_cause) else $error("off without match");
  property p_off_abort; channel_off_q |-> xfer_abort_q; endproperty
  a_off_abort: assert property (p_off_abort) else $error("off without abort");
  property p_start_pulse; xfer_start_q |=> !xfer_start_q; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_abort_pulse; xfer_abort_q |=> !xfer_abort_q; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
endmodule
`default_nettype wire

// [dv/dei_channel_event_irq_ctrl_test.sv]
// Purpose: Register and event tests of the channel event block.
// Assumes: Wishbone ack one cycle after request.
// Notes: Far side driven through the model tasks.
`timescale 1ns/1ps
`default_nettype none
module dei_channel_event_irq_ctrl_test;
  logic clock = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 0;
  logic [3:0] sel = 4'h0, bsel = 4'hF;
  logic [31:0] dat = 0, rd, dat_o;
  logic ack, st, ab, off, irq, ch_on;
  logic [255:0] lines;
  logic [15:0] sp, ss, dp, ds;
  logic [3:0] stro;
  int err_count = 0, compares = 0;
  logic [7:0] ab_sel [2] = '{8'h00, 8'h05};
  logic [7:0] st_sel [2] = '{8'hFF, 8'h09};
  always #2 clock = ~clock;
  dei_far_model i_dei_far_model (.clock(clock), .irq_lines(lines), .channel_on(ch_on),
    .source_pointer(sp), .source_size(ss), .destination_pointer(dp),
    .destination_size(ds), .strobes(stro));
  dei_channel_ctrl i_dei_channel_ctrl (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_lines(lines), .channel_on(ch_on),
    .source_pointer(sp), .source_size(ss), .destination_pointer(dp),
    .destination_size(ds), .cell_done(stro[0]), .block_done(stro[1]),
    .pattern_match(stro[2]), .addr_error(stro[3]), .xfer_start_q(st),
    .xfer_abort_q(ab), .channel_off_q(off), .irq_out(irq));
  task results();
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Classic single cycle, held until ack
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_o;
    if (ack !== 1'b1) begin
      err_count++;
      results();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("read", rd, e);
  endtask
  // Watch {off, abort, start} pulses for six edges
  task wt(input logic [2:0] e);
    logic [2:0] s;
    s = 3'b000;
    repeat (6) begin
      @(posedge clock);
      s = s | {off, ab, st};
    end
    chk("event", {29'h0, s}, {29'h0, e});
  endtask
  task ichk(input logic e);
    #1;
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rdc(4'h0, 32'h00FFFF00);
    rdc(4'h4, 32'h0);
    rdc(4'h1, 32'h0);
    wb(1'b1, 4'h4, 32'hFFFFFFFF);
    rdc(4'h4, 32'h00FF0000);
    // Boundary and mid selector numbers
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 4'h0, {8'h00, ab_sel[i], st_sel[i], 8'hD8});
      rdc(4'h0, {8'h00, ab_sel[i], st_sel[i], 8'h18});
      i_dei_far_model.fire(st_sel[i]);
      wt(3'b001);
      i_dei_far_model.fire(ab_sel[i]);
      wt(3'b010);
      rdc(4'h4, 32'h00FF0002);
      ichk(1'b1);
      wb(1'b1, 4'h4, 32'h00FF0000);
      rdc(4'h4, 32'h00FF0000);
    end
    // Middle lane only: start selector moves, low lane strobes ignored
    bsel = 4'h2;
    wb(1'b1, 4'h0, 32'h00AABBC0);
    wt(3'b000);
    rdc(4'h0, 32'h0005BB18);
    bsel = 4'hF;
    // Enables clear: lines ignored
    wb(1'b1, 4'h0, 32'h00050900);
    i_dei_far_model.fire(9);
    wt(3'b000);
    i_dei_far_model.fire(5);
    wt(3'b000);
    rdc(4'h4, 32'h00FF0000);
    wb(1'b1, 4'h0, 32'h00000080);
    wt(3'b001);
    wb(1'b1, 4'h0, 32'h00000040);
    wt(3'b010);
    wb(1'b1, 4'h0, 32'h00000020);
    i_dei_far_model.pulse(2);
    wt(3'b110);
    rdc(4'h4, 32'h00FF0008);
    // Strobes and pointer marks, zero size meaning largest
    i_dei_far_model.pulse(0);
    i_dei_far_model.pulse(1);
    i_dei_far_model.pulse(3);
    i_dei_far_model.ptrs(16'h0008, 16'h0010, 16'h8000, 16'h0000);
    i_dei_far_model.ptrs(16'h0010, 16'h0010, 16'h0000, 16'h0000);
    rdc(4'h4, 32'h00FF00FD);
    ichk(1'b1);
    // Mask, enable and clear
    wb(1'b1, 4'h4, 32'h0);
    ichk(1'b0);
    i_dei_far_model.pulse(0);
    ichk(1'b0);
    wb(1'b1, 4'h4, 32'h00040004);
    ichk(1'b1);
    rdc(4'h8, 32'h00000004);
    rdc(4'hC, 32'h00000003);
    wb(1'b1, 4'h8, 32'h00000004);
    ichk(1'b0);
    // Compares idle while the channel is off, then mark on return
    i_dei_far_model.set_on(1'b0);
    i_dei_far_model.ptrs(16'h0008, 16'h0010, 16'h0000, 16'h0000);
    rdc(4'hC, 32'h00000000);
    rdc(4'h4, 32'h00040000);
    i_dei_far_model.set_on(1'b1);
    rdc(4'h4, 32'h00040060);
    results();
  end
endmodule
bind dei_channel_ctrl dei_chan_props i_dei_chan_props (.clock(clock), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pattern_match(pattern_match),
  .xfer_start_q(xfer_start_q), .xfer_abort_q(xfer_abort_q), .channel_off_q(channel_off_q));
`default_nettype wire

// [dv/dei_far_model.sv]
// Purpose: Interrupt lines and datapath seen by the channel.
// Assumes: Driven at rising edges.
// Notes: Strobe index 0 cell, 1 block, 2 pattern, 3 addr error.
`timescale 1ns/1ps
`default_nettype none
`include "dei_chan_regs.vh"
module dei_far_model (
  input wire logic clock,
  output var logic [`DEI_IRQ_COUNT-1:0] irq_lines,
  output var logic channel_on,
  output var logic [15:0] source_pointer,
  output var logic [15:0] source_size,
  output var logic [15:0] destination_pointer,
  output var logic [15:0] destination_size,
  output var logic [3:0] strobes
);
  // Sizes chosen so no pointer matches at start
  initial begin
    irq_lines = '0;
    channel_on = 1'b1;
    source_pointer = 16'h0001;
    source_size = 16'h0010;
    destination_pointer = 16'h0001;
    destination_size = 16'h0010;
    strobes = 4'h0;
  end
  task fire(input int n);
    @(posedge clock);
    irq_lines[n] <= 1'b1;
    @(posedge clock);
    irq_lines[n] <= 1'b0;
  endtask
  task pulse(input int k);
    @(posedge clock);
    strobes[k] <= 1'b1;
    @(posedge clock);
    strobes[k] <= 1'b0;
  endtask
  task set_on(input logic v);
    @(posedge clock);
    channel_on <= v;
    @(posedge clock);
  endtask
  task ptrs(input logic [15:0] sp, ss, dp, ds);
    @(posedge clock);
    source_pointer <= sp;
    source_size <= ss;
    destination_pointer <= dp;
    destination_size <= ds;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire
